// >>> rtl/eq_fir_pkg.sv
// Package of constants for the nine-tap equalizer filter.
package eq_fir_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_COEF_A = 8'h40;
  localparam logic [7:0] ADDR_COEF_B = 8'h80;
  localparam int COEF_SEL_BIT = 6;
  localparam int COEF_IDX_LO = 2;
  // ****************************************
  // Control fields
  // ****************************************
  localparam int MODE_LSB = 0;
  localparam int SHARE_BIT = 2;
  localparam int MERGE_BIT = 3;
  localparam int WEIGHT_LSB = 4;
  localparam int LINKMODE_BIT = 8;
  localparam int SINGLE_IN_BIT = 9;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_ON = 2'h2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // ****************************************
  // Datapath
  // ****************************************
  localparam int TAPS = 9;
  localparam int CENTER = 4;
  localparam int SAMPLE_W = 12;
  localparam int CENTER_W = 18;
  localparam int SIDE_W = 12;
  localparam int CENTER_FRAC = 16;
  localparam int WEIGHT_MAX = 6;
  localparam int ACC_W = 36;
  typedef enum logic [1:0] {
    CFG_BYPASS = 2'b00,
    CFG_DUAL = 2'b01,
    CFG_SINGLE = 2'b11,
    CFG_TVF = 2'b10
  } cfg_t;
endpackage

// >>> rtl/equalizer_filter.sv
// Nine-tap equalizer filter with AXI4-Lite coefficient and mode registers.
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module equalizer_filter
  import eq_fir_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Sample streams, one sample per channel per cycle
  input wire logic [eq_fir_pkg::SAMPLE_W-1:0] samp_a_in,
  input wire logic [eq_fir_pkg::SAMPLE_W-1:0] samp_b_in,
  input wire logic samp_valid_in,
  output logic [eq_fir_pkg::SAMPLE_W-1:0] samp_a_out,
  output logic [eq_fir_pkg::SAMPLE_W-1:0] samp_b_out,
  output logic samp_valid_out
);
  import eq_fir_pkg::*;

  // ****************************************
  // Registers
  // ****************************************
  logic [31:0] ctrl_r;
  logic [CENTER_W-1:0] coef_a_r [TAPS];
  logic [CENTER_W-1:0] coef_b_r [TAPS];
  logic aw_hold_r, w_hold_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;

  wire logic [1:0] mode_w = ctrl_r[MODE_LSB +: 2];
  wire logic share_w = ctrl_r[SHARE_BIT];
  wire logic merge_w = ctrl_r[MERGE_BIT];
  wire logic [2:0] weight_w = ctrl_r[WEIGHT_LSB +: 3];
  wire logic link_single_w = ctrl_r[LINKMODE_BIT];
  wire logic single_in_w = ctrl_r[SINGLE_IN_BIT];
  // Illegal combinations fall back to bypass so a misprogrammed part passes data untouched.
  wire cfg_t cfg_w = (mode_w != MODE_ON) ? CFG_BYPASS :
    (!share_w && !merge_w && !link_single_w) ? CFG_DUAL :
    (share_w && merge_w && link_single_w) ? CFG_SINGLE :
    (!share_w && merge_w && link_single_w && !single_in_w) ? CFG_TVF :
    CFG_BYPASS;

  // Write side: address and data may arrive in either order.
  wire logic aw_have = aw_hold_r || s_axi_awvalid;
  wire logic w_have = w_hold_r || s_axi_wvalid;
  wire logic wr_go = aw_have && w_have && !s_axi_bvalid;
  wire logic [7:0] wa = aw_hold_r ? awaddr_r : s_axi_awaddr;
  wire logic [31:0] wd = w_hold_r ? wdata_r : s_axi_wdata;
  wire logic [3:0] ws = w_hold_r ? wstrb_r : s_axi_wstrb;
  wire logic wa_coef = (wa[7:COEF_SEL_BIT] != 2'h0) && (wa[COEF_SEL_BIT-1:COEF_IDX_LO] < 4'(TAPS));
  wire logic wa_ok = (wa == ADDR_CTRL) || (wa == ADDR_STATUS) || wa_coef;
  wire logic [3:0] w_idx = wa[COEF_SEL_BIT-1:COEF_IDX_LO];
  wire logic [31:0] wmask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wa_ok ? 2'h0 : 2'h2;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_r && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_r <= CTRL_RESET;
    else if (wr_go && wa == ADDR_CTRL)
      ctrl_r <= (ctrl_r & ~wmask) | (wd & wmask & 32'h0000_037f);
  end

  // two banks of nine coefficients; bank B is channel B, the set for both outputs in single mode, or the second time-varying set.
  genvar gi;
  generate
    for (gi = 0; gi < TAPS; gi++)
    begin : g_coef
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          coef_a_r[gi] <= '0;
          coef_b_r[gi] <= '0;
        end
        else if (wr_go && wa_coef && w_idx == 4'(gi))
        begin
          if (wa[COEF_SEL_BIT+1])
            coef_b_r[gi] <= (coef_b_r[gi] & ~wmask[CENTER_W-1:0]) | (wd[CENTER_W-1:0] & wmask[CENTER_W-1:0]);
          else
            coef_a_r[gi] <= (coef_a_r[gi] & ~wmask[CENTER_W-1:0]) | (wd[CENTER_W-1:0] & wmask[CENTER_W-1:0]);
        end
      end
    end
  endgenerate

  // ****************************************
  // Read channel
  // ****************************************
  wire logic [7:0] ra = s_axi_araddr;
  wire logic ra_coef = (ra[7:COEF_SEL_BIT] != 2'h0) && (ra[COEF_SEL_BIT-1:COEF_IDX_LO] < 4'(TAPS));
  wire logic [3:0] r_idx = ra[COEF_SEL_BIT-1:COEF_IDX_LO];
  wire logic [CENTER_W-1:0] r_coef = ra[COEF_SEL_BIT+1] ? coef_b_r[r_idx] : coef_a_r[r_idx];
  wire logic [31:0] rd_mux = (ra == ADDR_CTRL) ? ctrl_r :
    (ra == ADDR_STATUS) ? {30'h0, cfg_w} :
    ra_coef ? {{(32-CENTER_W){1'b0}}, r_coef} : 32'h0000_0000;
  wire logic rd_ok = (ra == ADDR_CTRL) || (ra == ADDR_STATUS) || ra_coef;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
  assign s_axi_arready = !s_axi_rvalid;

  // ****************************************
  // Filter datapath
  // ****************************************
  // Single and time-varying configurations treat A then B as two successive samples.
  logic [SAMPLE_W-1:0] dly_a_r [TAPS];
  logic [SAMPLE_W-1:0] dly_b_r [TAPS];
  logic signed [ACC_W-1:0] acc_a, acc_b;
  wire logic interleave = (cfg_w == CFG_SINGLE) || (cfg_w == CFG_TVF);

  function automatic logic signed [ACC_W-1:0] prod(input logic [CENTER_W-1:0] c,
    input logic [SAMPLE_W-1:0] s, input logic ctr, input logic [2:0] wt);
    logic signed [ACC_W-1:0] cv;
    cv = ctr ? ACC_W'($signed(c)) : ACC_W'($signed(c[SIDE_W-1:0]));
    // Side taps are shifted up so every product lands on the 2^-16 grid.
    if (!ctr)
      cv = cv <<< (WEIGHT_MAX - int'(wt > 3'(WEIGHT_MAX) ? 3'(WEIGHT_MAX) : wt));
    return cv * ACC_W'($signed(s));
  endfunction

  function automatic logic [SAMPLE_W-1:0] rnd_sat(input logic signed [ACC_W-1:0] a);
    logic signed [ACC_W-1:0] q;
    logic half, odd, sticky;
    q = a >>> CENTER_FRAC;
    half = a[CENTER_FRAC-1];
    sticky = |a[CENTER_FRAC-2:0];
    odd = q[0];
    if (half && (sticky || odd))
      q = q + ACC_W'(1);
    if (q > ACC_W'((1 << (SAMPLE_W-1)) - 1))
      return {1'b0, {(SAMPLE_W-1){1'b1}}};
    else if (q < -ACC_W'(1 << (SAMPLE_W-1)))
      return {1'b1, {(SAMPLE_W-1){1'b0}}};
    return q[SAMPLE_W-1:0];
  endfunction

  always_comb
  begin
    acc_a = '0;
    acc_b = '0;
    for (int k = 0; k < TAPS; k++)
    begin
      if (interleave)
      begin
        // Newest sample is B; A output uses taps ending at A, B output at B.
        acc_b = acc_b + prod(coef_b_r[k], (k % 2 == 0) ? dly_b_r[k/2] : dly_a_r[k/2], k == CENTER, weight_w);
        acc_a = acc_a + prod((cfg_w == CFG_TVF) ? coef_a_r[k] : coef_b_r[k],
          (k % 2 == 0) ? dly_a_r[k/2] : dly_b_r[k/2 + 1], k == CENTER, weight_w);
      end
      else
      begin
        acc_a = acc_a + prod(coef_a_r[k], dly_a_r[k], k == CENTER, weight_w);
        acc_b = acc_b + prod(coef_b_r[k], dly_b_r[k], k == CENTER, weight_w);
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int k = 0; k < TAPS; k++)
      begin
        dly_a_r[k] <= '0;
        dly_b_r[k] <= '0;
      end
      samp_a_out <= '0;
      samp_b_out <= '0;
      samp_valid_out <= 1'b0;
    end
    else
    begin
      samp_valid_out <= samp_valid_in;
      if (samp_valid_in)
      begin
        dly_a_r[0] <= samp_a_in;
        dly_b_r[0] <= samp_b_in;
        for (int k = 1; k < TAPS; k++)
        begin
          dly_a_r[k] <= dly_a_r[k-1];
          dly_b_r[k] <= dly_b_r[k-1];
        end
        if (cfg_w == CFG_BYPASS)
        begin
          samp_a_out <= samp_a_in;
          samp_b_out <= samp_b_in;
        end
        else
        begin
          samp_a_out <= rnd_sat(acc_a);
          samp_b_out <= rnd_sat(acc_b);
        end
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_bypass_passes: assert property (@(posedge aclk) disable iff (!aresetn)
    (samp_valid_in && mode_w == MODE_OFF) |=> samp_a_out == $past(samp_a_in))
    else $error("Bypass did not pass sample A through.");
  a_cfg_decode: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode_w == MODE_ON && share_w && merge_w && link_single_w) |-> cfg_w == CFG_SINGLE)
    else $error("Share and merge did not select single equalization.");
  a_out_holds_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    !samp_valid_in |=> $stable(samp_a_out) && $stable(samp_b_out))
    else $error("Output sample changed without an input sample.");
  a_valid_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    samp_valid_in |=> samp_valid_out)
    else $error("Output valid did not follow input valid.");
  a_dual_needs_link: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg_w == CFG_DUAL |-> !link_single_w)
    else $error("Dual equalization active in single link mode.");
  a_tvf_needs_dual_in: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg_w == CFG_TVF |-> (link_single_w && !single_in_w))
    else $error("Time varying filter active without dual input.");
endmodule // equalizer_filter

// >>> bench/converter_source.sv
// Converter core model that feeds sample pairs to the filter.
`timescale 1ns/1ps
module converter_source
  import eq_fir_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bench control
  input wire logic go,
  // Sample pairs toward the filter
  output logic [eq_fir_pkg::SAMPLE_W-1:0] samp_a,
  output logic [eq_fir_pkg::SAMPLE_W-1:0] samp_b,
  output logic samp_valid
);
  int seed = 36;
  logic take;
  initial
  begin
    samp_a = '0;
    samp_b = '0;
    samp_valid = 1'b0;
  end
  // Random gaps model a slow core; idle data toggles so stale values never look valid.
  always @(posedge aclk)
  begin
    take = aresetn && go && (($random(seed) & 3) != 0);
    samp_valid <= take;
    samp_a <= take ? SAMPLE_W'($random(seed)) : ~samp_a;
    samp_b <= take ? SAMPLE_W'($random(seed)) : ~samp_b;
  end
endmodule // converter_source

// >>> bench/test_equalizer_filter.sv
// Self-checking bench for the nine-tap equalizer filter.
`timescale 1ns/1ps
module test_equalizer_filter;
  import eq_fir_pkg::*;
  logic aclk = 0, aresetn = 0, go = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, samp_valid_in, samp_valid_out;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [11:0] samp_a_in, samp_b_in, samp_a_out, samp_b_out;
  logic [17:0] mc [2][9];
  logic signed [11:0] ha [9], hb [9], hs [10];
  cfg_t mcfg = CFG_BYPASS;
  int wc = 0, skip = 0, fail_count = 0, compares = 0, seed = 36;
  logic [24:0] expq [$];
  logic [24:0] g;
  logic [23:0] e;
  initial forever #2.5 aclk = ~aclk;
  equalizer_filter dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .samp_a_in, .samp_b_in, .samp_valid_in,
    .samp_a_out, .samp_b_out, .samp_valid_out);
  converter_source src (.aclk, .aresetn, .go, .samp_a(samp_a_in), .samp_b(samp_b_in),
    .samp_valid(samp_valid_in));
  // ****
  // Checking and bus tasks
  // ****
  task automatic chk_reg(input logic [31:0] got, exp, input string what);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_samp(input logic [23:0] got, exp);
    chk_reg({8'h0, got}, {8'h0, exp}, "sample");
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk_reg({30'h0, s_axi_bresp}, {30'h0, er}, "bresp");
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk_reg(s_axi_rdata, ed, "rdata");
    chk_reg({30'h0, s_axi_rresp}, {30'h0, er}, "rresp");
  endtask
  // Taps are written symmetric, so the model need not know which end is newest.
  task automatic load(input bit bk, input logic [17:0] cs);
    logic [17:0] v;
    logic [7:0] ba;
    ba = bk ? ADDR_COEF_B : ADDR_COEF_A;
    for (int k = 0; k < 5; k++)
    begin
      v = cs != 0 ? (k == 4 ? cs : 18'h0) : 18'($random(seed));
      wr(ba + 8'(4 * k), 32'(v), 2'h0);
      wr(ba + 8'(32 - 4 * k), 32'(v), 2'h0);
      mc[bk][k] = v;
      mc[bk][8 - k] = v;
    end
  endtask
  task automatic run(input logic [31:0] ctrl, input cfg_t c, input int n);
    wr(ADDR_CTRL, ctrl, 2'h0);
    rd(ADDR_STATUS, 32'(c), 2'h0);
    mcfg = c;
    wc = int'(ctrl[6:4]);
    skip = 9;
    go <= 1'b1;
    repeat (n) @(posedge aclk);
    go <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
  task automatic conclude();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ****
  // Reference filter
  // ****
  function automatic logic [11:0] fir(input int s, input bit bk);
    longint acc, c, x, q;
    acc = 0;
    for (int k = 0; k < 9; k++)
    begin
      c = k == 4 ? $signed(mc[bk][k]) : $signed(mc[bk][k][11:0]) <<< (6 - wc);
      x = s == 0 ? ha[k] : s == 1 ? hb[k] : hs[k + s - 2];
      acc += c * x;
    end
    q = acc >>> 16;
    if (acc[15:0] > 16'h8000 || (acc[15:0] == 16'h8000 && q[0])) q++;
    if (q > 2047) q = 2047;
    if (q < -2048) q = -2048;
    return q[11:0];
  endfunction
  always @(posedge aclk)
  begin
    if (aresetn && samp_valid_in === 1'b1)
    begin
      // The filtered result leaves with the taps held before this sample enters.
      case (mcfg)
        CFG_DUAL: e = {fir(0, 0), fir(1, 1)};
        CFG_SINGLE: e = {fir(3, 1), fir(2, 1)};
        CFG_TVF: e = {fir(3, 0), fir(2, 1)};
        default: e = {samp_a_in, samp_b_in};
      endcase
      for (int k = 9; k > 1; k--) hs[k] = hs[k - 2];
      for (int k = 8; k > 0; k--) ha[k] = ha[k - 1];
      for (int k = 8; k > 0; k--) hb[k] = hb[k - 1];
      ha[0] = samp_a_in;
      hb[0] = samp_b_in;
      hs[1] = samp_a_in;
      hs[0] = samp_b_in;
      expq.push_back({skip == 0, e});
      if (skip > 0) skip--;
    end
  end
  // An output with no note pending is checked against all ones on both samples (12'hfff each).
  always @(posedge aclk)
  begin
    if (aresetn && samp_valid_out === 1'b1)
    begin
      g = expq.size() ? expq.pop_front() : 25'h1ffffff;
      if (g[24]) chk_samp({samp_a_out, samp_b_out}, g[23:0]);
    end
  end
  // ****
  // Main sequence
  // ****
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_CTRL, CTRL_RESET, 2'h0);
    rd(ADDR_STATUS, 32'h0, 2'h0);
    rd(8'h08, 32'h0, 2'h2);
    wr(8'h3c, 32'h1, 2'h2);
    wr(ADDR_COEF_A + 8'h10, 32'hffff_ffff, 2'h0);
    rd(ADDR_COEF_A + 8'h10, 32'h0003_ffff, 2'h0);
    load(0, 0);
    load(1, 0);
    run(32'h0000_000c, CFG_BYPASS, 40);
    for (int w = 0; w < 7; w++) run(32'h2 | 32'(w << 4), CFG_DUAL, 30);
    run(32'h0000_0102, CFG_BYPASS, 20);
    run(32'h0000_030e, CFG_SINGLE, 40);
    run(32'h0000_000e, CFG_BYPASS, 20);
    load(0, 18'h1ffff);
    load(1, 18'h08000);
    run(32'h0000_010a, CFG_TVF, 60);
    run(32'h0000_030a, CFG_BYPASS, 20);
    chk_reg(32'(expq.size()), 32'h0, "drain");
    conclude();
  end
  initial
  begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    conclude();
  end
endmodule // test_equalizer_filter
